// [cpsf_framer.sv]
// camera framer: pixel capture, sync code insertion, line counting, power modes
// and the serialiser running on the bit clock supplied by the clock multiplier.
// assumes LINK_CLK is eight times the pixel rate and runs while PLL_RUN is high.
`timescale 1ns/1ps
// Overview of operation
// - shutdown input filtered against short pulses
// - pulses under glitch window rejected
// - pixel byte taken at pixel clock fall
// - valid strobes produce frame/line sync codes
// - codes are ff,00,00,type
// - serialise bytes, free serial clock at 8x
// - both modes: lsb first, byte aligned
// - mode high: forced frame end at limit
// - line counter limited to 2046 lines in mode high
// - shutdown disables outputs and multiplier loop
// - stopped pixel clock enters standby
// - blanking holds data lane high
module cpsf_framer #(
  parameter int MAX_LINES_P = cpsf_pkg::MAX_LINES
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic LINK_CLK,
  input wire logic SHUTDOWN_CONTROL,
  input wire logic MODE,
  input wire logic PIXEL_CLOCK_IN,
  input wire logic FRAME_VALID,
  input wire logic LINE_VALID,
  input wire logic [7:0] PIXEL_BYTE,
  output logic PLL_RUN,
  output logic SER_DATA,
  output logic SER_DATA_OE,
  output logic SER_CLK_EN
);
  // two-flop synchronisers for all pins: {byte, mode, shutdown, pclk, fv, lv}
  logic [12:0] pin_s1_q, pin_s2_q, pin_s1_d;
  logic pclk_prev_q, pclk_prev_d;
  always_comb
  begin
    pin_s1_d = {PIXEL_BYTE, MODE, SHUTDOWN_CONTROL, PIXEL_CLOCK_IN, FRAME_VALID, LINE_VALID};
    pclk_prev_d = pin_s2_q[2];
  end
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pclk_prev_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s1_q;
      pclk_prev_q <= pclk_prev_d;
    end
  end
  logic lv_s, fv_s, sd_s, mode_s, tick;
  logic [7:0] byte_s;
  assign lv_s = pin_s2_q[0];
  assign fv_s = pin_s2_q[1];
  assign sd_s = pin_s2_q[3];
  assign mode_s = pin_s2_q[4];
  assign byte_s = pin_s2_q[12:5];
  assign tick = pclk_prev_q & ~pin_s2_q[2]; // falling pixel clock edge

  // power control: glitch filter and standby detector
  logic en_q, en_d; // filtered shutdown level, high = run
  logic [cpsf_pkg::CNT_W-1:0] gl_cnt_q, gl_cnt_d, idle_cnt_q, idle_cnt_d;
  logic stby_q, stby_d, pll_q, pll_d;
  always_comb
  begin
    en_d = en_q;
    gl_cnt_d = '0;
    // level must differ for a full window before it is believed
    if (sd_s != en_q)
    begin
      if (gl_cnt_q == cpsf_pkg::CNT_W'(cpsf_pkg::GLITCH_CYC - 1))
        en_d = sd_s;
      else
        gl_cnt_d = gl_cnt_q + 1'b1;
    end
    // silence counter restarts on every pixel clock fall
    idle_cnt_d = idle_cnt_q;
    stby_d = stby_q;
    if (tick)
    begin
      idle_cnt_d = '0;
      stby_d = 1'b0; // clock is back
    end
    else if (idle_cnt_q == cpsf_pkg::CNT_W'(cpsf_pkg::STANDBY_CYC - 1))
      stby_d = 1'b1;
    else
      idle_cnt_d = idle_cnt_q + 1'b1;
    pll_d = en_q; // multiplier loop stops only in shutdown
  end
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      en_q <= 1'b0;
      gl_cnt_q <= '0;
      idle_cnt_q <= '0;
      stby_q <= 1'b1;
      pll_q <= 1'b0;
    end
    else
    begin
      en_q <= en_d;
      gl_cnt_q <= gl_cnt_d;
      idle_cnt_q <= idle_cnt_d;
      stby_q <= stby_d;
      pll_q <= pll_d;
    end
  end
  assign PLL_RUN = pll_q;
  logic active;
  assign active = en_q & ~stby_q;

  // framer: pixel delay line lets a four-byte code go ahead of pixel 0
  logic [7:0] dly_q [cpsf_pkg::DLY_DEPTH];
  logic [7:0] dly_d [cpsf_pkg::DLY_DEPTH];
  logic [cpsf_pkg::DLY_DEPTH-1:0] dlv_q, dlv_d; // line valid per entry
  logic lv_prev_q, lv_prev_d, fv_prev_q, fv_prev_d, tail_prev_q, tail_prev_d;
  logic first_q, first_d, ovf_q, ovf_d, eof_pend_q, eof_pend_d;
  logic code_busy_q, code_busy_d;
  logic [1:0] code_idx_q, code_idx_d;
  cpsf_pkg::cpsf_code_t code_q, code_d;
  logic [10:0] line_cnt_q, line_cnt_d;
  logic [7:0] out_q, out_d;
  logic tog_q, tog_d; // flips once per byte slot for the link side
  logic lv_eff;
  assign lv_eff = lv_s & fv_s & ~ovf_q; // lines past the limit are dropped
  generate
    for (genvar i = 0; i < cpsf_pkg::DLY_DEPTH; i++)
    begin : g_dly
      // each entry takes its neighbour on a pixel tick; head split off so
      // no index below zero is ever formed
      if (i == 0)
      begin : g_head
        always_comb
        begin
          dly_d[i] = tick ? byte_s : dly_q[i];
        end
      end
      else
      begin : g_tail
        always_comb
        begin
          dly_d[i] = tick ? dly_q[i-1] : dly_q[i];
        end
      end
      always_ff @(posedge CLK or negedge ARST_N)
      begin
        if (!ARST_N)
          dly_q[i] <= '0;
        else
          dly_q[i] <= dly_d[i];
      end
    end
  endgenerate
  always_comb
  begin
    dlv_d = dlv_q;
    lv_prev_d = lv_prev_q;
    fv_prev_d = fv_prev_q;
    tail_prev_d = tail_prev_q;
    first_d = first_q;
    ovf_d = ovf_q;
    eof_pend_d = eof_pend_q;
    code_busy_d = code_busy_q;
    code_idx_d = code_idx_q;
    code_d = code_q;
    line_cnt_d = line_cnt_q;
    out_d = out_q;
    tog_d = tog_q;
    if (!active)
    begin
      // framing restarts cleanly after shutdown or standby
      dlv_d = '0;
      lv_prev_d = 1'b0;
      fv_prev_d = 1'b0;
      tail_prev_d = 1'b0;
      code_busy_d = 1'b0;
      eof_pend_d = 1'b0;
      out_d = cpsf_pkg::IDLE_BYTE;
    end
    else if (tick)
    begin
      dlv_d = {dlv_q[cpsf_pkg::DLY_DEPTH-2:0], lv_eff};
      lv_prev_d = lv_eff;
      fv_prev_d = fv_s;
      tail_prev_d = dlv_q[cpsf_pkg::DLY_DEPTH-1];
      // frame boundaries
      if (fv_s && !fv_prev_q)
      begin
        first_d = 1'b1;
        ovf_d = 1'b0;
        line_cnt_d = '0;
      end
      if (!fv_s && fv_prev_q && !ovf_q)
        eof_pend_d = 1'b1;
      // pick a new code: line start, then line end, then frame end
      if (lv_eff && !lv_prev_q)
      begin
        code_busy_d = 1'b1;
        code_idx_d = '0;
        // frame valid may rise on this very tick, so both are looked at
        code_d = (first_q || (fv_s && !fv_prev_q)) ? cpsf_pkg::CPSF_FRAME_START : cpsf_pkg::CPSF_LINE_START;
        first_d = 1'b0;
      end
      else if (!dlv_q[cpsf_pkg::DLY_DEPTH-1] && tail_prev_q)
      begin
        code_busy_d = 1'b1;
        code_idx_d = '0;
        line_cnt_d = line_cnt_q + 1'b1;
        // limit reached in mode high: close the frame instead
        if (mode_s && (line_cnt_q == 11'(MAX_LINES_P - 1)))
        begin
          code_d = cpsf_pkg::CPSF_FRAME_END;
          ovf_d = 1'b1;
        end
        else
          code_d = cpsf_pkg::CPSF_LINE_END;
      end
      else if (eof_pend_q && !code_busy_q && !dlv_q[cpsf_pkg::DLY_DEPTH-1])
      begin
        code_busy_d = 1'b1;
        code_idx_d = '0;
        code_d = cpsf_pkg::CPSF_FRAME_END;
        eof_pend_d = 1'b0;
      end
      else if (code_busy_q)
      begin
        code_idx_d = code_idx_q + 1'b1;
        if (code_idx_q == 2'(cpsf_pkg::CODE_LEN - 1))
          code_busy_d = 1'b0;
      end
      // byte for this slot
      if (code_busy_d)
      begin
        case (code_idx_d)
          2'h0: out_d = cpsf_pkg::CODE_LEAD;
          2'h1: out_d = cpsf_pkg::CODE_ZERO;
          2'h2: out_d = cpsf_pkg::CODE_ZERO;
          default: out_d = {6'h00, code_d};
        endcase
      end
      else if (dlv_q[cpsf_pkg::DLY_DEPTH-1])
        out_d = dly_q[cpsf_pkg::DLY_DEPTH-1]; // delayed pixel
      else
        out_d = cpsf_pkg::IDLE_BYTE;
      tog_d = ~tog_q; // one byte per pixel period
    end
  end
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      dlv_q <= '0;
      lv_prev_q <= 1'b0;
      fv_prev_q <= 1'b0;
      tail_prev_q <= 1'b0;
      first_q <= 1'b0;
      ovf_q <= 1'b0;
      eof_pend_q <= 1'b0;
      code_busy_q <= 1'b0;
      code_idx_q <= '0;
      code_q <= cpsf_pkg::CPSF_LINE_START;
      line_cnt_q <= '0;
      out_q <= cpsf_pkg::IDLE_BYTE;
      tog_q <= 1'b0;
    end
    else
    begin
      dlv_q <= dlv_d;
      lv_prev_q <= lv_prev_d;
      fv_prev_q <= fv_prev_d;
      tail_prev_q <= tail_prev_d;
      first_q <= first_d;
      ovf_q <= ovf_d;
      eof_pend_q <= eof_pend_d;
      code_busy_q <= code_busy_d;
      code_idx_q <= code_idx_d;
      code_q <= code_d;
      line_cnt_q <= line_cnt_d;
      out_q <= out_d;
      tog_q <= tog_d;
    end
  end

  // link side: out_q is stable a full pixel period, so the toggle handshake
  // only needs the event synchronised; the word is read after that.
  logic [2:0] l_tog_q, l_tog_d; // two sync flops plus edge history
  logic [1:0] l_act_q, l_act_d;
  logic [7:0] pend_q, pend_d, sh_q, sh_d;
  logic [2:0] bit_q, bit_d;
  logic sd_q, sd_d, oe_q, oe_d, ck_q, ck_d;
  always_comb
  begin
    l_tog_d = {l_tog_q[1:0], tog_q};
    l_act_d = {l_act_q[0], active};
    pend_d = (l_tog_q[2] != l_tog_q[1]) ? out_q : pend_q;
    sh_d = sh_q >> 1; // lsb leaves first
    bit_d = bit_q + 1'b1;
    if (bit_q == 3'(cpsf_pkg::BITS_PER_BYTE - 1))
      sh_d = pend_q; // next byte right after the last bit
    if (!l_act_q[1])
    begin
      // disabled: lane idles high, realigned on wake
      sh_d = cpsf_pkg::IDLE_BYTE;
      pend_d = cpsf_pkg::IDLE_BYTE;
      bit_d = '0;
    end
    sd_d = sh_q[0];
    oe_d = l_act_q[1];
    ck_d = l_act_q[1]; // free running clock while enabled
  end
  always_ff @(posedge LINK_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      l_tog_q <= '0;
      l_act_q <= '0;
      pend_q <= cpsf_pkg::IDLE_BYTE;
      sh_q <= cpsf_pkg::IDLE_BYTE;
      bit_q <= '0;
      sd_q <= 1'b1;
      oe_q <= 1'b0;
      ck_q <= 1'b0;
    end
    else
    begin
      l_tog_q <= l_tog_d;
      l_act_q <= l_act_d;
      pend_q <= pend_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      sd_q <= sd_d;
      oe_q <= oe_d;
      ck_q <= ck_d;
    end
  end
  assign SER_DATA = sd_q;
  assign SER_DATA_OE = oe_q;
  assign SER_CLK_EN = ck_q;
endmodule // cpsf_framer

// [cpsf_pkg.sv]
// constants and code types for the camera parallel-to-serial framer
// assumes a 200 MHz system clock and a separate serial bit clock domain
package cpsf_pkg;
  // system clock period and derived timing counts
  localparam int CLK_PERIOD_NS = 5;
  localparam int GLITCH_WINDOW_NS = 3800; // least suppressed pulse width
  localparam int GLITCH_WINDOW_MAX_NS = 10000; // longest suppressed width
  localparam int GLITCH_CYC = (GLITCH_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STANDBY_NS = 2400; // pixel clock silence before standby
  localparam int STANDBY_CYC = (STANDBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  // per-frame line limit
  localparam int MAX_LINES = 2046;
  // sync code layout: lead byte, two zero bytes, type byte
  localparam int CODE_LEN = 4;
  localparam logic [7:0] CODE_LEAD = 8'hff;
  localparam logic [7:0] CODE_ZERO = 8'h00;
  localparam logic [7:0] IDLE_BYTE = 8'hff; // lane held high in blanking
  localparam int DLY_DEPTH = 4; // pixel delay covers one code
  localparam int BITS_PER_BYTE = 8;
  // synchronisation code types
  typedef enum logic [1:0] {
    CPSF_LINE_START = 2'b00,
    CPSF_LINE_END = 2'b01,
    CPSF_FRAME_START = 2'b10,
    CPSF_FRAME_END = 2'b11
  } cpsf_code_t;
endpackage

// [cpsf_framer_properties.sv]
// checker on the framer top ports: pin filter, power states, lane level
// assumes a bind to cpsf_framer; run-length counters use the system clock
`timescale 1ns/1ps
module cpsf_framer_properties (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic LINK_CLK,
  input wire logic SHUTDOWN_CONTROL,
  input wire logic PIXEL_CLOCK_IN,
  input wire logic FRAME_VALID,
  input wire logic PLL_RUN,
  input wire logic SER_DATA,
  input wire logic SER_DATA_OE,
  input wire logic SER_CLK_EN
);
  localparam int GW = cpsf_pkg::GLITCH_CYC; // filter window in cycles
  logic [11:0] hi_q, lo_q, st_q, fl_q; // run lengths, saturating
  logic pc_q; // pixel clock one cycle ago
  // saturate so a long idle never wraps into a false short run
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      hi_q <= '0;
      lo_q <= '0;
      st_q <= '0;
      fl_q <= '0;
      pc_q <= 1'b0;
    end
    else
    begin
      hi_q <= SHUTDOWN_CONTROL ? hi_q + 12'(hi_q != '1) : '0;
      lo_q <= SHUTDOWN_CONTROL ? '0 : lo_q + 12'(lo_q != '1);
      st_q <= (PIXEL_CLOCK_IN != pc_q) ? '0 : st_q + 12'(st_q != '1);
      fl_q <= FRAME_VALID ? '0 : fl_q + 12'(fl_q != '1);
      pc_q <= PIXEL_CLOCK_IN;
    end
  end
  // loop held off for eight link cycles
  sequence s_pll_quiet;
    !PLL_RUN [*8];
  endsequence
  a_rise_filtered: assert property (@(posedge CLK) disable iff (!ARST_N) $rose(PLL_RUN) |-> hi_q >= GW)
    else $error("run rose early");
  a_fall_filtered: assert property (@(posedge CLK) disable iff (!ARST_N) $fell(PLL_RUN) |-> lo_q >= GW)
    else $error("run fell early");
  a_run_follows: assert property (@(posedge CLK) disable iff (!ARST_N) hi_q == 12'd790 |-> PLL_RUN)
    else $error("run missing");
  a_off_follows: assert property (@(posedge CLK) disable iff (!ARST_N) lo_q == 12'd790 |-> !PLL_RUN)
    else $error("run stuck");
  a_shut_quiet: assert property (@(posedge LINK_CLK) disable iff (!ARST_N) s_pll_quiet |-> !SER_DATA_OE)
    else $error("lane on in shutdown");
  a_blank_high: assert property (@(posedge LINK_CLK) disable iff (!ARST_N) fl_q > 12'd2000 |-> SER_DATA)
    else $error("lane low in blanking");
  a_clk_with_lane: assert property (@(posedge LINK_CLK) disable iff (!ARST_N) $rose(SER_CLK_EN) |-> PLL_RUN && SER_DATA_OE)
    else $error("clock gate differs");
  a_standby_off: assert property (@(posedge LINK_CLK) disable iff (!ARST_N) st_q > 12'd700 |-> !SER_DATA_OE)
    else $error("lane on in standby");
endmodule // cpsf_framer_properties

// [cpsf_host_model.sv]
// pixel clock source and serial receiver standing for camera and host
// assumes lane launched on rising link clock, so taken mid-bit at its fall;
// pixel clock locked to the link clock; idle ff runs collapse to one
`timescale 1ns/1ps
module cpsf_host_model (
  input wire logic link_clk,
  input wire logic run,
  input wire logic sd,
  input wire logic oe,
  output logic pclk
);
  logic [31:0] sr = '1; // last 32 lane bits
  logic lock = 1'b0; // byte edge found
  logic ffp = 1'b0; // idle byte pending
  int nb = 0; // bits into byte
  int hc = 0; // half period count
  logic [7:0] q[$]; // bytes seen
  initial pclk = 1'b0;
  // exactly one pixel per eight link bits, as a locked multiplier gives;
  // a slower camera would starve the shifter; stands still when stopped
  always @(posedge link_clk)
  begin
    hc <= run ? (hc + 1) % 4 : 0;
    if (run && hc == 3)
      pclk <= ~pclk;
  end
  // lsb first; lock on the frame start code only
  always @(negedge link_clk)
  begin
    if (oe === 1'b1)
    begin
      sr = {sd, sr[31:1]};
      nb = (nb + 1) % 8;
      if (!lock && sr == 32'h020000ff)
      begin
        lock = 1'b1;
        nb = 0;
        ffp = 1'b0;
        q = {8'hff, 8'h00, 8'h00, 8'h02};
      end
      else if (lock && nb == 0)
      begin
        if (sr[31:24] == 8'hff)
          ffp = 1'b1;
        else
        begin
          if (ffp)
            q.push_back(8'hff);
          ffp = 1'b0;
          q.push_back(sr[31:24]);
        end
      end
    end
  end
endmodule // cpsf_host_model

// [cpsf_framer_tb_top.sv]
// bench for the framer: clocks, reset, scenarios and verdict
// assumes the host model beside the design; line limit shortened to 2
`timescale 1ns/1ps
module cpsf_framer_tb_top;
  localparam int LIM = 2; // shortened line limit
  logic clk, link_clk, arst_n, shut, mode, fv, lv, run, pclk;
  logic pll_run, ser_data, ser_oe, ser_clk_en;
  logic [7:0] pbyte;
  int n_errors = 0;
  int checks = 0;
  cpsf_framer #(.MAX_LINES_P(LIM)) cpsf_framer_inst (.CLK(clk), .ARST_N(arst_n), .LINK_CLK(link_clk),
    .SHUTDOWN_CONTROL(shut), .MODE(mode), .PIXEL_CLOCK_IN(pclk), .FRAME_VALID(fv), .LINE_VALID(lv),
    .PIXEL_BYTE(pbyte), .PLL_RUN(pll_run), .SER_DATA(ser_data), .SER_DATA_OE(ser_oe), .SER_CLK_EN(ser_clk_en));
  cpsf_host_model cpsf_host_model_inst (.link_clk(link_clk), .run(run), .sd(ser_data),
    .oe(ser_oe), .pclk(pclk));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // link clock offset so its phase bears no relation to clk
  initial
  begin
    link_clk = 1'b0;
    #7.3;
    forever #24 link_clk = ~link_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // steps to the next pixel slot, off the capture edge
  task automatic px(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      @(negedge clk);
    end
  endtask
  task automatic wait_oe;
    for (int i = 0; i < 300 && ser_oe !== 1'b1; i++)
      cyc(1);
    chk("lane on", ser_oe, 1);
    chk("clock on", ser_clk_en, 1);
  endtask
  // pulses of 2 us either way must not move the loop
  task automatic t_glitch;
    shut = 1'b1;
    cyc(400);
    shut = 1'b0;
    cyc(900);
    chk("run high pulse", pll_run, 0);
    shut = 1'b1;
    cyc(800);
    chk("run on", pll_run, 1);
    shut = 1'b0;
    cyc(400);
    shut = 1'b1;
    cyc(900);
    chk("run low pulse", pll_run, 1);
  endtask
  // frame of nl lines of four pixels; forced end when over the limit with m high
  task automatic t_frame(input int nl, input logic m);
    logic [7:0] e[$];
    logic f;
    f = m && nl > LIM;
    mode = m;
    cpsf_host_model_inst.lock = 1'b0;
    cpsf_host_model_inst.q.delete();
    for (int l = 0; l < (f ? LIM : nl); l++)
    begin
      e = {e, 8'hff, 8'h00, 8'h00, (l == 0) ? 8'h02 : 8'h00};
      for (int p = 0; p < 4; p++)
        e.push_back(8'(16 * l + p + 1));
      e = {e, 8'hff, 8'h00, 8'h00, (f && l == LIM - 1) ? 8'h03 : 8'h01};
    end
    if (!f)
      e = {e, 8'hff, 8'h00, 8'h00, 8'h03};
    px(1);
    for (int l = 0; l < nl; l++)
    begin
      fv = 1'b1;
      lv = 1'b1;
      for (int p = 0; p < 4; p++)
      begin
        pbyte = 8'(16 * l + p + 1);
        px(1);
      end
      lv = 1'b0;
      px(10);
    end
    fv = 1'b0;
    px(20);
    chk("byte count", cpsf_host_model_inst.q.size(), e.size());
    foreach (e[i]) chk("lane byte", cpsf_host_model_inst.q[i], e[i]);
    if (f)
      chk("line dropped", 32'(cpsf_host_model_inst.q.size() <= e.size()), 1);
  endtask
  task automatic t_standby;
    run = 1'b0;
    cyc(800);
    chk("standby lane", ser_oe, 0);
    chk("standby clock", ser_clk_en, 0);
    run = 1'b1;
    wait_oe;
  endtask
  task automatic t_shutdown;
    shut = 1'b0;
    cyc(900);
    chk("shutdown run", pll_run, 0);
    chk("shutdown lane", ser_oe, 0);
    chk("shutdown clock", ser_clk_en, 0);
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    {arst_n, shut, mode, fv, lv, pbyte} = '0;
    run = 1'b1;
    cyc(16);
    chk("reset run", pll_run, 0);
    chk("reset lane", {ser_oe, ser_data}, 1);
    arst_n = 1'b1;
    t_glitch();
    wait_oe();
    t_frame(2, 1'b0);
    t_frame(3, 1'b1);
    t_standby();
    t_shutdown();
    end_of_test();
  end
  // cut a hang well past the expected 14000 cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
endmodule // cpsf_framer_tb_top
bind cpsf_framer cpsf_framer_properties cpsf_framer_properties_inst (.CLK(CLK), .ARST_N(ARST_N),
  .LINK_CLK(LINK_CLK), .SHUTDOWN_CONTROL(SHUTDOWN_CONTROL), .PIXEL_CLOCK_IN(PIXEL_CLOCK_IN),
  .FRAME_VALID(FRAME_VALID), .PLL_RUN(PLL_RUN), .SER_DATA(SER_DATA), .SER_DATA_OE(SER_DATA_OE),
  .SER_CLK_EN(SER_CLK_EN));
